// ---- test/nps_host_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nps_host_tb;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_rd;
	logic        wb_ack;
	logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb, saw_low;
	logic [7:0]  io_o, io_m, io_w;
	logic        fail_req = 1'b0;
	logic        rew_req = 1'b0;
	logic [31:0] rd;
	int          failures = 0;
	int          n_compared = 0;

	always #5 sys_clk = ~sys_clk;
	assign io_w = io_oe ? io_o : io_m;

	nps_host nps_host_inst (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .nand_ce_n(ce_n),
		.nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
		.nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(io_oe), .nand_io_i(io_w),
		.ready_busy_out(rb));
	nps_nand_model nps_nand_model_inst (.sys_clk(sys_clk), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_w), .io_out(io_m),
		.ready_busy_out(rb), .fail_req(fail_req), .rew_req(rew_req));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic single cycle; the answer is awaited, never assumed
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_dat <= dat;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		saw_low = 1'b0;
		do begin
			wb(1'b0, nps_pkg::REG_STATUS, 32'h0);
			if (rd[1] === 1'b0)
				saw_low = 1'b1;
			n++;
		end while (rd[0] !== 1'b0 && n < 500);
		if (n >= 500)
			failures++;
	endtask
	task automatic cmd(input logic [3:0] op);
		wb(1'b1, nps_pkg::REG_CMD, {28'h0, op});
		wait_idle();
	endtask
	task automatic wdata(input logic [7:0] b);
		wb(1'b1, nps_pkg::REG_DATA, {24'h0, b});
		cmd(4'h2);
	endtask
	task automatic setadr(input logic [7:0] p, input logic [11:0] c);
		wb(1'b1, nps_pkg::REG_ADDR, {8'h00, p, 4'h0, c});
	endtask

	task automatic t_reset();
		check(32'(wp_n), 32'h0);
		wb(1'b0, nps_pkg::REG_ADDR, 32'h0);
		check(rd, nps_pkg::ADDR_RESET);
		wb(1'b0, nps_pkg::REG_CFG, 32'h0);
		check(rd, nps_pkg::CFG_RESET);
		wb(1'b0, 8'h1C, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, nps_pkg::REG_STATUS, 32'h0);
		check(32'(rd[1:0]), 32'h2);
		$display("test reset done");
	endtask
	task automatic t_program();
		wb(1'b1, nps_pkg::REG_CFG, 32'h1);
		setadr(8'h01, 12'h004);
		cmd(4'h0);
		wdata(8'h11);
		wdata(8'h22);
		wdata(8'h33);
		setadr(8'h01, 12'h014);
		cmd(4'h1);
		wdata(8'h44);
		wdata(8'h55);
		cmd(4'h3);
		check(32'(saw_low), 32'h1);
		check(32'(rd[6:3]), 32'h8);
		check(32'(rd[15:8]), 32'hE0);
		check(32'(nps_nand_model_inst.mem[1][4]), 32'h11);
		check(32'(nps_nand_model_inst.mem[1][6]), 32'h33);
		check(32'(nps_nand_model_inst.mem[1][7]), 32'hFF);
		check(32'(nps_nand_model_inst.mem[1][20]), 32'h44);
		check(32'(nps_nand_model_inst.mem[1][21]), 32'h55);
		$display("test program done");
	endtask
	task automatic t_erase_fail();
		fail_req <= 1'b1;
		setadr(8'h01, 12'h000);
		wb(1'b1, nps_pkg::REG_CMD, 32'h4);
		wb(1'b1, nps_pkg::REG_CMD, 32'h0);
		wait_idle();
		check(32'(rd[4:2]), 32'h3);
		check(32'(nps_nand_model_inst.mem[1][4]), 32'hFF);
		wb(1'b1, nps_pkg::REG_STATUS, 32'h4);
		wb(1'b0, nps_pkg::REG_STATUS, 32'h0);
		check(32'(rd[2]), 32'h0);
		fail_req <= 1'b0;
		$display("test erase_fail done");
	endtask
	task automatic t_copyback();
		rew_req <= 1'b1;
		setadr(8'h02, 12'h000);
		cmd(4'h5);
		check(32'(rd[4:3]), 32'h2);
		rew_req <= 1'b0;
		setadr(8'h03, 12'h008);
		cmd(4'h6);
		wdata(8'hA5);
		cmd(4'hA);
		wb(1'b0, nps_pkg::REG_DATA, 32'h0);
		check(rd, 32'h89);
		cmd(4'h3);
		check(32'(rd[4:3]), 32'h0);
		check(32'(nps_nand_model_inst.mem[3][8]), 32'hA5);
		check(32'(nps_nand_model_inst.mem[3][9]), 32'h89);
		check(32'(nps_nand_model_inst.mem[3][0]), 32'h80);
		$display("test copyback done");
	endtask
	task automatic t_protect();
		wb(1'b1, nps_pkg::REG_CFG, 32'h0);
		setadr(8'h00, 12'h000);
		cmd(4'h0);
		wdata(8'h12);
		cmd(4'h3);
		check(32'(wp_n), 32'h0);
		check(32'(nps_nand_model_inst.mem[0][0]), 32'h00);
		check(32'(rd[5]), 32'h1);
		$display("test protect done");
	endtask
	task automatic t_status();
		cmd(4'h8);
		check(32'(rd[15:8]), 32'h60);
		for (int i = 0; i < 2; i++) begin
			cmd(4'h9);
			check(32'(rd[15:8]), 32'h60);
		end
		$display("test status done");
	endtask
	task automatic t_id();
		cmd(4'h7);
		wb(1'b0, nps_pkg::REG_ID0, 32'h0);
		check(rd, 32'h6586C35A);
		wb(1'b0, nps_pkg::REG_ID1, 32'h0);
		check(32'(rd[16:0]), 32'h196F2);
		$display("test id done");
	endtask
	task automatic t_opcodes();
		cmd(4'hB);
		check(32'(saw_low), 32'h1);
		check(32'(rd[6]), 32'h1);
		wb(1'b1, nps_pkg::REG_CMD, 32'hC);
		wb(1'b0, nps_pkg::REG_STATUS, 32'h0);
		check(32'(rd[2:0]), 32'h6);
		$display("test opcodes done");
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_program();
		t_erase_fail();
		t_copyback();
		t_protect();
		t_status();
		t_id();
		t_opcodes();
		tally_and_finish();
	end
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- test/nps_nand_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nps_nand_model #(
	parameter int         BUSY_CYC = 40,
	parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value
	parameter logic [7:0] ID_DEV   = 8'hC3, // Arbitrary value
	parameter logic [7:0] ID_B3    = 8'h86,
	parameter logic [7:0] ID_B4    = 8'h65,
	parameter logic [7:0] ID_B5    = 8'hF2
) (
	// Clock
	input  wire logic       sys_clk,
	// Flash pins
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] io_in,
	output logic [7:0]      io_out,
	output logic            ready_busy_out,
	// Fault injection
	input  wire logic       fail_req,
	input  wire logic       rew_req
);
	// Only four pages of 64 columns: the column high byte is ignored
	logic [7:0]  mem [4][64];
	logic [7:0]  pbuf [64];
	logic [7:0]  ids [5];
	logic [5:0]  col_q = 6'h00;
	logic [15:0] page_q = 16'h0000;
	logic [2:0]  acnt_q = 3'h0;
	logic [7:0]  mode_q = 8'h00;
	logic [2:0]  id_q = 3'h0;
	logic [7:0]  last_q = 8'h00;
	logic        we_q = 1'b1;
	logic        re_q = 1'b1;
	logic        fail_q = 1'b0;
	logic        rew_q = 1'b0;
	logic        rdy;
	logic [7:0]  stat;
	int          busy_q = 0;

	initial begin
		for (int p = 0; p < 4; p++)
			for (int c = 0; c < 64; c++)
				mem[p][c] = {p[1:0], c[5:0]};
	end
	assign ids = '{ID_MAKER, ID_DEV, ID_B3, ID_B4, ID_B5};
	assign rdy = busy_q == 0;
	assign ready_busy_out = rdy;
	assign stat = {wp_n, rdy, rdy, 1'b0, rew_q, 2'b00, fail_q};
	// A released bus shows the inverse so a stale byte is never mistaken for data
	assign io_out = re_n ? ~last_q : last_q;

	// Plain always: the array is also preloaded by an initial block
	always @(posedge sys_clk) begin
		we_q <= we_n;
		re_q <= re_n;
		if (busy_q > 0)
			busy_q <= busy_q - 1;
		if (!ce_n && !we_q && we_n) begin
			if (cle) begin
				mode_q <= io_in;
				acnt_q <= (io_in == 8'h60) ? 3'h2 : 3'h0;
				if (io_in == 8'h80)
					for (int c = 0; c < 64; c++) pbuf[c] <= 8'hFF;
				if (io_in == 8'h90)
					id_q <= 3'h0;
				if (io_in inside {8'h10, 8'hD0, 8'h35, 8'hFF}) begin
					busy_q <= BUSY_CYC;
					fail_q <= fail_req;
					rew_q <= (io_in == 8'h35) && rew_req;
				end
				if (io_in == 8'h10 && wp_n)
					for (int c = 0; c < 64; c++) mem[page_q[1:0]][c] <= pbuf[c];
				if (io_in == 8'hD0 && wp_n)
					for (int c = 0; c < 64; c++) mem[page_q[1:0]][c] <= 8'hFF;
				if (io_in == 8'h35)
					for (int c = 0; c < 64; c++) pbuf[c] <= mem[page_q[1:0]][c];
			end else if (ale) begin
				case (acnt_q)
					3'h0: col_q <= io_in[5:0];
					3'h2: page_q[7:0] <= io_in;
					3'h3: page_q[15:8] <= io_in;
					default: ;
				endcase
				acnt_q <= acnt_q + 3'h1;
			end else begin
				pbuf[col_q] <= io_in;
				col_q <= col_q + 6'h01;
			end
		end
		if (!ce_n && re_q && !re_n) begin
			if (mode_q == 8'h70) begin
				last_q <= stat;
			end else if (mode_q == 8'h90) begin
				last_q <= ids[id_q];
				id_q <= id_q + 3'h1;
			end else begin
				last_q <= pbuf[col_q];
				col_q <= col_q + 6'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verilog/nps_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module nps_host #(
	parameter int STROBE_CYC  = nps_pkg::STROBE_CYC,
	parameter int WB_WAIT_CYC = nps_pkg::WB_WAIT_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Flash pins
	output logic             nand_ce_n,
	output logic             nand_cle,
	output logic             nand_ale,
	output logic             nand_we_n,
	output logic             nand_re_n,
	output logic             nand_wp_n,
	output logic [7:0]       nand_io_o,
	output logic             nand_io_oe,
	input  wire logic [7:0]  nand_io_i,
	input  wire logic        ready_busy_out
);
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_ISSUE     = 2'b01,
		ST_WAIT_LOW  = 2'b10,
		ST_WAIT_HIGH = 2'b11
	} nps_st_t;

	initial begin
		if (WB_WAIT_CYC < 1 || WB_WAIT_CYC > 255) begin
			$error("WB_WAIT_CYC out of range");
		end
	end

	// Returns {last, kind, byte} for one pin cycle of an operation
	function automatic logic [10:0] nps_step(input nps_pkg::nps_op_t op,
		input logic [2:0] idx, input logic [31:0] adr, input logic [7:0] dat);
		logic [7:0] cl;
		logic [7:0] ch;
		logic [7:0] pl;
		logic [7:0] ph;
		logic [10:0] s;
		cl = adr[7:0];
		ch = {4'h0, adr[11:8]};
		pl = adr[23:16];
		ph = adr[31:24];
		s = {1'b1, nps_pkg::PK_DRD, 8'h00};
		unique case (op)
			nps_pkg::OP_PROG_SETUP, nps_pkg::OP_COPY_DEST, nps_pkg::OP_COPY_READ: begin
				unique case (idx)
					3'd0: s = {1'b0, nps_pkg::PK_CMD, (op == nps_pkg::OP_PROG_SETUP)
						? nps_pkg::CMD_SERIAL_IN : (op == nps_pkg::OP_COPY_DEST)
						? nps_pkg::CMD_COL_CHG : nps_pkg::CMD_READ}; // [R8] [R6]
					3'd1: s = {1'b0, nps_pkg::PK_ADDR, cl}; // [R22]
					3'd2: s = {1'b0, nps_pkg::PK_ADDR, ch};
					3'd3: s = {1'b0, nps_pkg::PK_ADDR, pl};
					3'd4: s = {op != nps_pkg::OP_COPY_READ, nps_pkg::PK_ADDR, ph};
					default: s = {1'b1, nps_pkg::PK_CMD, nps_pkg::CMD_COPY_RD}; // [R6]
				endcase
			end
			nps_pkg::OP_COL_CHANGE: begin
				unique case (idx)
					3'd0: s = {1'b0, nps_pkg::PK_CMD, nps_pkg::CMD_COL_CHG}; // [R2] [R9]
					3'd1: s = {1'b0, nps_pkg::PK_ADDR, cl};
					default: s = {1'b1, nps_pkg::PK_ADDR, ch};
				endcase
			end
			nps_pkg::OP_DATA_WR: s = {1'b1, nps_pkg::PK_DWR, dat}; // [R24]
			nps_pkg::OP_PROG_CONF: s = {1'b1, nps_pkg::PK_CMD, nps_pkg::CMD_CONFIRM}; // [R1]
			nps_pkg::OP_ERASE: begin
				unique case (idx)
					3'd0: s = {1'b0, nps_pkg::PK_CMD, nps_pkg::CMD_ERASE}; // [R4]
					3'd1: s = {1'b0, nps_pkg::PK_ADDR, pl};
					3'd2: s = {1'b0, nps_pkg::PK_ADDR, ph};
					default: s = {1'b1, nps_pkg::PK_CMD, nps_pkg::CMD_ERASE_GO}; // [R4]
				endcase
			end
			nps_pkg::OP_ID_READ: begin
				unique case (idx)
					3'd0: s = {1'b0, nps_pkg::PK_CMD, nps_pkg::CMD_ID};
					3'd1: s = {1'b0, nps_pkg::PK_ADDR, 8'h00};
					default: s = {idx == 3'd6, nps_pkg::PK_DRD, 8'h00}; // [R17]
				endcase
			end
			nps_pkg::OP_STATUS: begin
				if (idx == 3'd0) begin
					s = {1'b0, nps_pkg::PK_CMD, nps_pkg::CMD_STATUS};
				end
			end
			nps_pkg::OP_RESET: s = {1'b1, nps_pkg::PK_CMD, nps_pkg::CMD_RESET};
			default: s = {1'b1, nps_pkg::PK_DRD, 8'h00}; // [R10]
		endcase
		return s;
	endfunction

	function automatic logic [31:0] nps_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	nps_st_t          st_q;
	nps_pkg::nps_op_t op_q;
	logic [2:0]       idx_q;
	logic             launch_q;
	logic [7:0]       wait_q;
	logic [31:0]      addr_q;
	logic [31:0]      cfg_q;
	logic [7:0]       data_q;
	logic [7:0]       stat_q;
	logic [7:0]       id_q [5];
	logic             refused_q;
	logic             wr_fire;
	logic             cmd_fire;
	logic             cmd_ok;
	logic [10:0]      step;
	logic             pc_start;
	logic             pc_done;
	logic [7:0]       pc_rd;
	logic             last_done;
	logic             needs_wait;
	logic [31:0]      status_word;
	logic [31:0]      rd_mux;

	assign wr_fire  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
	assign cmd_fire = wr_fire && wb_adr_i == nps_pkg::REG_CMD && wb_sel_i[0];
	// Only status and reset may go out while the device reports busy
	assign cmd_ok = wb_dat_i[3:0] <= nps_pkg::OP_RESET && (ready_busy_out
		|| wb_dat_i[3:0] == nps_pkg::OP_STATUS || wb_dat_i[3:0] == nps_pkg::OP_STATUS_RD
		|| wb_dat_i[3:0] == nps_pkg::OP_RESET); // [R21] [R16]
	assign step       = nps_step(op_q, idx_q, addr_q, data_q);
	assign pc_start   = (st_q == ST_ISSUE) && !launch_q;
	assign last_done  = pc_done && step[10];
	assign needs_wait = op_q == nps_pkg::OP_PROG_CONF || op_q == nps_pkg::OP_ERASE
		|| op_q == nps_pkg::OP_COPY_READ || op_q == nps_pkg::OP_RESET;
	assign nand_ce_n  = (st_q == ST_IDLE);
	assign nand_wp_n  = cfg_q[nps_pkg::CFG_WREN_BIT]; // [R23]

	nps_pin_cycle #(
		.STROBE_CYC(STROBE_CYC)
	) u_pin (
		.sys_clk(sys_clk),
		.srst   (srst),
		.start  (pc_start),
		.kind   (step[9:8]),
		.wr_byte(step[7:0]),
		.done   (pc_done),
		.rd_byte(pc_rd),
		.cle    (nand_cle),
		.ale    (nand_ale),
		.we_n   (nand_we_n),
		.re_n   (nand_re_n),
		.io_o   (nand_io_o),
		.io_oe  (nand_io_oe),
		.io_i   (nand_io_i)
	);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q     <= ST_IDLE;
			op_q     <= nps_pkg::OP_STATUS;
			idx_q    <= 3'd0;
			launch_q <= 1'b0;
			wait_q   <= 8'h00;
		end else begin
			if (pc_start) launch_q <= 1'b1;
			if (pc_done) launch_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (cmd_fire && cmd_ok) begin
						op_q  <= nps_pkg::nps_op_t'(wb_dat_i[3:0]);
						idx_q <= 3'd0;
						st_q  <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (pc_done) begin
						idx_q <= idx_q + 3'd1;
						if (step[10]) begin
							st_q <= needs_wait ? ST_WAIT_LOW : ST_IDLE; // [R1] [R4]
						end
					end
					wait_q <= 8'h00;
				end
				ST_WAIT_LOW: begin
					// Busy may show late or be too short to see
					wait_q <= wait_q + 8'h01;
					if (!ready_busy_out || wait_q == 8'(WB_WAIT_CYC - 1)) begin
						st_q <= ST_WAIT_HIGH;
					end
				end
				ST_WAIT_HIGH: begin
					if (ready_busy_out) begin // [R5] [R20]
						op_q  <= nps_pkg::OP_STATUS; // [R7] [R13]
						idx_q <= 3'd0;
						st_q  <= ST_ISSUE;
					end
				end
			endcase
		end
	end

	// Column tracks the device's own counter across data bytes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			addr_q <= nps_pkg::ADDR_RESET;
		end else if (wr_fire && wb_adr_i == nps_pkg::REG_ADDR) begin
			addr_q <= nps_merge(addr_q, wb_dat_i, wb_sel_i);
		end else if (pc_done && (op_q == nps_pkg::OP_DATA_WR || op_q == nps_pkg::OP_DATA_RD)) begin
			addr_q[11:0] <= addr_q[11:0] + 12'h001; // [R24] [R3]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_q <= nps_pkg::CFG_RESET;
		end else if (wr_fire && wb_adr_i == nps_pkg::REG_CFG) begin
			cfg_q <= nps_merge(cfg_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			data_q <= 8'h00;
		end else if (last_done && op_q == nps_pkg::OP_DATA_RD) begin
			data_q <= pc_rd;
		end else if (wr_fire && wb_adr_i == nps_pkg::REG_DATA && wb_sel_i[0]) begin
			data_q <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stat_q <= 8'h00;
		end else if (last_done && (op_q == nps_pkg::OP_STATUS || op_q == nps_pkg::OP_STATUS_RD)) begin
			stat_q <= pc_rd; // [R10]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < 5; i++) id_q[i] <= 8'h00;
		end else if (pc_done && op_q == nps_pkg::OP_ID_READ && idx_q >= 3'd2) begin
			id_q[idx_q - 3'd2] <= pc_rd; // [R17]
		end
	end

	// A new refusal wins over a software clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			refused_q <= 1'b0;
		end else if (cmd_fire && (st_q != ST_IDLE || !cmd_ok)) begin
			refused_q <= 1'b1; // [R21]
		end else if (wr_fire && wb_adr_i == nps_pkg::REG_STATUS && wb_dat_i[2]) begin
			refused_q <= 1'b0;
		end
	end

	assign status_word = {16'h0000, stat_q, 1'b0,
		stat_q[6] & stat_q[5], // [R11]
		!stat_q[7], // [R15]
		stat_q[3], // [R14]
		stat_q[0] & stat_q[6], // [R12] [R13]
		refused_q, ready_busy_out, st_q != ST_IDLE};

	always_comb begin
		unique case (wb_adr_i)
			nps_pkg::REG_ADDR:   rd_mux = addr_q;
			nps_pkg::REG_DATA:   rd_mux = {24'h000000, data_q};
			nps_pkg::REG_STATUS: rd_mux = status_word;
			nps_pkg::REG_ID0:    rd_mux = {id_q[3], id_q[2], id_q[1], id_q[0]};
			nps_pkg::REG_ID1:    rd_mux = {15'h0000, id_q[3][6], id_q[3][5:4], id_q[3][1:0],
				id_q[2][3:2], id_q[2][1:0], id_q[4]}; // [R18] [R19]
			nps_pkg::REG_CFG:    rd_mux = cfg_q;
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

	a_erase_pair: assert property (@(posedge sys_clk) disable iff (srst) // [R4]
		pc_start && step[7:0] == nps_pkg::CMD_ERASE_GO && step[9:8] == nps_pkg::PK_CMD
		|-> op_q == nps_pkg::OP_ERASE && idx_q == 3'd3)
		else $error("erase start out of sequence");

	a_confirm_wait: assert property (@(posedge sys_clk) disable iff (srst) // [R1]
		st_q == ST_ISSUE && last_done && op_q == nps_pkg::OP_PROG_CONF
		|=> st_q == ST_WAIT_LOW)
		else $error("confirm not followed by busy wait");

	a_busy_only_status: assert property (@(posedge sys_clk) disable iff (srst) // [R21]
		pc_start && step[9:8] == nps_pkg::PK_CMD && !ready_busy_out && st_q == ST_ISSUE
		&& idx_q == 3'd0 |-> step[7:0] == nps_pkg::CMD_STATUS || step[7:0] == nps_pkg::CMD_RESET
		|| op_q != nps_pkg::OP_STATUS && op_q != nps_pkg::OP_RESET && $past(st_q) == ST_ISSUE)
		else $error("command sent while busy");

	a_col_advance: assert property (@(posedge sys_clk) disable iff (srst) // [R24]
		pc_done && op_q == nps_pkg::OP_DATA_WR && !wr_fire
		|=> addr_q[11:0] == $past(addr_q[11:0]) + 12'h001)
		else $error("column did not advance");

	a_id_order: assert property (@(posedge sys_clk) disable iff (srst) // [R17]
		pc_done && op_q == nps_pkg::OP_ID_READ && idx_q == 3'd2 |=> id_q[0] == $past(pc_rd))
		else $error("first id byte misplaced");

	a_busy_hold: assert property (@(posedge sys_clk) disable iff (srst) // [R5]
		st_q == ST_WAIT_HIGH && !ready_busy_out |=> st_q == ST_WAIT_HIGH)
		else $error("left busy wait early");

	a_status_after: assert property (@(posedge sys_clk) disable iff (srst) // [R13]
		st_q == ST_WAIT_HIGH && ready_busy_out
		|=> op_q == nps_pkg::OP_STATUS && st_q == ST_ISSUE ##[1:40] pc_start)
		else $error("no status read after ready");

	a_copy_dest: assert property (@(posedge sys_clk) disable iff (srst) // [R8]
		pc_start && op_q == nps_pkg::OP_COPY_DEST && idx_q == 3'd0
		|-> step[7:0] == nps_pkg::CMD_COL_CHG && step[9:8] == nps_pkg::PK_CMD)
		else $error("copy destination without 85h");

	a_addr_count: assert property (@(posedge sys_clk) disable iff (srst) // [R22]
		last_done && op_q == nps_pkg::OP_PROG_SETUP |-> idx_q == 3'd4)
		else $error("address not four cycles");
endmodule
`default_nettype wire

// ---- verilog/nps_pin_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
module nps_pin_cycle #(
	parameter int STROBE_CYC = nps_pkg::STROBE_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       srst,
	// Request
	input  wire logic       start,
	input  wire logic [1:0] kind,
	input  wire logic [7:0] wr_byte,
	output logic            done,
	output logic [7:0]      rd_byte,
	// Flash pins
	output logic            cle,
	output logic            ale,
	output logic            we_n,
	output logic            re_n,
	output logic [7:0]      io_o,
	output logic            io_oe,
	input  wire logic [7:0] io_i
);
	typedef enum logic [1:0] {
		PC_IDLE  = 2'b00,
		PC_SETUP = 2'b01,
		PC_LOW   = 2'b10,
		PC_HIGH  = 2'b11
	} nps_pc_t;

	initial begin
		if (STROBE_CYC < 1 || STROBE_CYC > 255) begin
			$error("STROBE_CYC out of range");
		end
	end

	nps_pc_t    st_q;
	logic [7:0] cnt_q;
	logic [1:0] kind_q;
	logic       cnt_end;

	assign cnt_end = (cnt_q == 8'(STROBE_CYC - 1));
	assign done    = (st_q == PC_HIGH) && cnt_end;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q  <= PC_IDLE;
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_end ? 8'h00 : cnt_q + 8'h01;
			unique case (st_q)
				PC_IDLE: begin
					cnt_q <= 8'h00;
					if (start) begin
						st_q <= PC_SETUP;
					end
				end
				PC_SETUP: if (cnt_end) st_q <= PC_LOW;
				PC_LOW:   if (cnt_end) st_q <= PC_HIGH;
				PC_HIGH:  if (cnt_end) st_q <= PC_IDLE;
			endcase
		end
	end

	// Latches and data stay put through the high phase for hold time
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			kind_q <= 2'b00;
			io_o   <= 8'h00;
			cle    <= 1'b0;
			ale    <= 1'b0;
			io_oe  <= 1'b0;
		end else if (st_q == PC_IDLE && start) begin
			kind_q <= kind;
			io_o   <= wr_byte;
			cle    <= (kind == nps_pkg::PK_CMD);
			ale    <= (kind == nps_pkg::PK_ADDR);
			io_oe  <= (kind != nps_pkg::PK_DRD);
		end else if (done) begin
			cle   <= 1'b0;
			ale   <= 1'b0;
			io_oe <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			we_n <= 1'b1;
			re_n <= 1'b1;
		end else begin
			we_n <= !((st_q == PC_SETUP && cnt_end) || (st_q == PC_LOW && !cnt_end))
				|| (kind_q == nps_pkg::PK_DRD);
			re_n <= !((st_q == PC_SETUP && cnt_end) || (st_q == PC_LOW && !cnt_end))
				|| (kind_q != nps_pkg::PK_DRD);
		end
	end

	// Sampled at the end of the low phase, well past the access time
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_byte <= 8'h00;
		end else if (st_q == PC_LOW && cnt_end && kind_q == nps_pkg::PK_DRD) begin
			rd_byte <= io_i;
		end
	end

	a_read_no_drive: assert property (@(posedge sys_clk) disable iff (srst)
		!re_n |-> !io_oe)
		else $error("io driven while reading");

	a_one_strobe: assert property (@(posedge sys_clk) disable iff (srst)
		!(!we_n && !re_n))
		else $error("both strobes low");
endmodule
`default_nettype wire

// ---- verilog/nps_pkg.sv ----
// Functional notes
// R1: After address and data, send 10h so the device programs the page.
// R2: Command 85h plus two address cycles sets a new column for data.
// R3: Column change may repeat freely within one page before 10h.
// R4: Erase is 60h, block address cycles, then D0h immediately after.
// R5: Once erase starts, wait for ready without further action.
// R6: Copy-back read 00h, address, 35h loads the whole page internally.
// R7: After copy-back read busy, check status before copy-back program.
// R8: Copy-back program is 85h with destination address, then 10h.
// R9: Random data input 85h may change bytes before the 10h confirm.
// R10: After 70h the device returns status on every read strobe.
// R11: Status bits 6 and 7 show ready as 1, busy as 0.
// R12: Status bit 1 shows fail as 1 after program or erase.
// R13: Pass/fail bit counts only once the device is ready.
// R14: Status bit 4 flags rewrite advised after read, else 0.
// R15: Status bit 8 is 0 when write-protected, 1 otherwise.
// R16: Status command is allowed while a read is busy.
// R17: ID read returns five bytes in fixed order.
// R18: ID byte 3 bits 2..1 chip count, bits 4..3 cell type.
// R19: ID byte 4 page size, block size and width fields.
// R20: Ready/busy is low during operations, high when done.
// R21: While busy, issue only status read or reset.
// R22: Full address is two column cycles then two page cycles.
// R23: Protect input low aborts and inhibits program and erase.
// R24: Each data byte goes to the current column, which then advances.
package nps_pkg;
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int T_STROBE_NS       = 25;
	localparam int STROBE_CYC        = (T_STROBE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int T_WB_NS           = 100;
	localparam int WB_WAIT_CYC       = (T_WB_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_ID0    = 8'h10;
	localparam logic [7:0] REG_ID1    = 8'h14;
	localparam logic [7:0] REG_CFG    = 8'h18;

	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
	localparam int          CFG_WREN_BIT = 0;

	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_CONFIRM   = 8'h10;
	localparam logic [7:0] CMD_COPY_RD   = 8'h35;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
	localparam logic [7:0] CMD_COL_CHG   = 8'h85;
	localparam logic [7:0] CMD_ID        = 8'h90;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
	localparam logic [7:0] CMD_RESET     = 8'hFF;

	typedef enum logic [1:0] {
		PK_CMD  = 2'b00,
		PK_ADDR = 2'b01,
		PK_DWR  = 2'b10,
		PK_DRD  = 2'b11
	} nps_kind_t;

	typedef enum logic [3:0] {
		OP_PROG_SETUP = 4'h0,
		OP_COL_CHANGE = 4'h1,
		OP_DATA_WR    = 4'h2,
		OP_PROG_CONF  = 4'h3,
		OP_ERASE      = 4'h4,
		OP_COPY_READ  = 4'h5,
		OP_COPY_DEST  = 4'h6,
		OP_ID_READ    = 4'h7,
		OP_STATUS     = 4'h8,
		OP_STATUS_RD  = 4'h9,
		OP_DATA_RD    = 4'hA,
		OP_RESET      = 4'hB
	} nps_op_t;
endpackage
